// [src/osa_pkg.sv]
package osa_pkg;

  // ==========================================================================
  // Slot indices (eight allocatable overhead parts)
  localparam int SLOT_FIRST_FREE  = 0;
  localparam int SLOT_CTRL_B56    = 1;
  localparam int SLOT_CTRL_B78    = 2;
  localparam int SLOT_SECOND_FREE = 3;
  localparam int SLOT_ALIGN_B1    = 4;
  localparam int SLOT_CTRL_B1     = 5;
  localparam int SLOT_CTRL_B3     = 6;
  localparam int SLOT_CTRL_B4     = 7;
  localparam int NUM_SLOTS        = 8;

  // Worth of each slot in 32nds of the overhead
  localparam logic [5:0] WORTH_BYTE = 6'h08;
  localparam logic [5:0] WORTH_PAIR = 6'h02;
  localparam logic [5:0] WORTH_BIT  = 6'h01;
  localparam logic [5:0] PARTS_MAX_SIDE   = 6'h15;
  localparam logic [5:0] PARTS_LEGACY_SVC = 6'h14;

  // ==========================================================================
  // Use codes
  typedef enum logic [2:0] {
    OSA_USE_UNUSED,
    OSA_USE_SVC,
    OSA_USE_SIDE,
    OSA_USE_CAS,
    OSA_USE_BA,
    OSA_USE_MFRAME,
    OSA_USE_SPAREBITS,
    OSA_USE_LOWRATE
  } osa_use_e;

  // Service-channel presets
  typedef enum logic [1:0] {
    OSA_SVC_OFF,
    OSA_SVC_LEGACY,
    OSA_SVC_CUSTOM,
    OSA_SVC_ALL
  } osa_svc_e;

  // Side-channel modes
  typedef enum logic [1:0] {
    OSA_SIDE_OFF,
    OSA_SIDE_LOWRATE,
    OSA_SIDE_MAX,
    OSA_SIDE_CUSTOM
  } osa_side_e;

  // ==========================================================================
  // Register map (APB byte addresses)
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_CUSTOM  = 12'h004;
  localparam logic [11:0] ADDR_ALLOC   = 12'h008;
  localparam logic [11:0] ADDR_STATUS  = 12'h00C;
  localparam logic [11:0] ADDR_RATEDIV = 12'h010;

  // Control field positions
  localparam int CTRL_SVC_LSB    = 0;
  localparam int CTRL_SIDE_LSB   = 2;
  localparam int CTRL_CUSTOM_FEAT = 4;
  localparam int CTRL_CAS        = 5;
  localparam int CTRL_CUSTOM_FRM = 6;
  localparam int CTRL_BA_EN      = 7;
  localparam int CTRL_MFRAME_EN  = 8;
  localparam int CTRL_E1_TRANSP  = 9;
  localparam int CTRL_SVC_HIRATE = 10;
  localparam int CTRL_MINOH      = 11;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0180;

  // Rate divisors as main-rate-to-channel-rate ratios, the max async percentage and the use code width
  localparam int LEGACY_BAUD_DIV  = 23;
  localparam int LOWRATE_DIV      = 2000;
  localparam int MAX_ASYNC_PCT    = 1;
  localparam int CODE_W           = 3;

endpackage

// [src/osa_cfg_if.sv]
`timescale 1ns/10ps
interface osa_cfg_if;
  // Custom use codes requested per slot and the resolved allocation
  logic [23:0] custom_codes;
  logic [23:0] alloc_codes;
  logic [7:0]  reject_mask;
  logic [5:0]  svc_parts;
  logic [5:0]  side_parts;

  modport top   (output custom_codes, input alloc_codes, input reject_mask, input svc_parts, input side_parts);
  modport alloc (input custom_codes, output alloc_codes, output reject_mask, output svc_parts, output side_parts);
endinterface

// [src/osa_rate_gen.sv]
`timescale 1ns/10ps
// ============================================================================
// Overhead slot enable generator: one pulse per overhead part
module osa_rate_gen #(
  parameter int DIV_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [DIV_W-1:0] div,
  output logic                  slot_tick,
  output logic [4:0]            part_idx
);
  initial begin
    if (DIV_W < 2) $error("DIV_W too small");
  end

  logic [DIV_W-1:0] cnt_reg;

  // Divider; a zero divisor ticks every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= div) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Part counter walks the 32 overhead parts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_tick <= 1'b0;
      part_idx  <= 5'h00;
    end else begin
      slot_tick <= (cnt_reg >= div);
      if (slot_tick) begin
        part_idx <= part_idx + 5'h01;
      end
    end
  end
endmodule

// [src/osa_slot_map.sv]
`timescale 1ns/10ps
// ============================================================================
// Part-to-slot map: which of the 8 allocatable slots owns a given 32nd
module osa_slot_map (
  input  wire logic [4:0] part_idx,
  output logic [3:0]      slot
);
  // Parts 0..7 first free byte, 8..15 second, then control/alignment bits
  always_comb begin
    if (part_idx < 5'h08) begin
      slot = 4'h0;
    end else if (part_idx < 5'h10) begin
      slot = 4'h3;
    end else begin
      unique case (part_idx)
        5'h10, 5'h11: slot = 4'h1;
        5'h12, 5'h13: slot = 4'h2;
        5'h14:        slot = 4'h4;
        5'h15:        slot = 4'h5;
        5'h16:        slot = 4'h6;
        5'h17:        slot = 4'h7;
        default:      slot = 4'h8; // Fixed framing, never allocatable
      endcase
    end
  end
endmodule

// [src/osa_top.sv]
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
// How it works
// - Max preset: side gets 21 parts
// - Max preset async rate up to 1 percent
// - Custom side needs custom features; shared step
// - Service choice needs hi-rate async, sync side
// - Legacy preset: service gets 20 parts
// - Legacy baud about terrestrial rate over 23
// - All-available: remaining parts go to service
// - Min overhead scales to service baud; CTRL_MINOH is stored in the control register but has no effect
// - Custom slot holds one use code
// - Free bytes worth 8, blocked by CAS
// - Control bit pairs worth 2, either channel
// - Alignment bit 1 service only
// - Control bit 1 low-rate or spare
// - Control bit 3 backward alarm unless disabled
// - Control bit 4 multiframe unless absent
// - Transparent spare bits block alignment/control slots
// - Low-rate mode: only control bit 1
module osa_top #(
  parameter int DIV_W = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        svc_tx_bit,
  input  wire logic        side_tx_bit,
  output logic             oh_tx_bit,
  output logic             oh_tx_valid,
  output logic [4:0]       oh_part_idx,
  input  wire logic        oh_rx_bit,
  output logic             svc_rx_bit,
  output logic             svc_rx_valid,
  output logic             side_rx_bit,
  output logic             side_rx_valid,
  output logic [15:0]      svc_baud_div,
  output logic [15:0]      side_async_div
);
  initial begin
    if (DIV_W < 2 || DIV_W > 32) $error("DIV_W out of range");
  end

  // ==========================================================================
  // Registers
  logic [31:0]      ctrl_reg;
  logic [23:0]      custom_reg;
  logic [DIV_W-1:0] ratediv_reg;
  logic             sel_err;

  osa_cfg_if cfg ();

  osa_pkg::osa_svc_e  svc_mode;
  osa_pkg::osa_side_e side_mode;
  logic custom_feat;
  logic side_custom_ok;
  logic svc_choice_ok;

  assign svc_mode    = osa_pkg::osa_svc_e'(ctrl_reg[osa_pkg::CTRL_SVC_LSB +: 2]);
  assign side_mode   = osa_pkg::osa_side_e'(ctrl_reg[osa_pkg::CTRL_SIDE_LSB +: 2]);
  assign custom_feat = ctrl_reg[osa_pkg::CTRL_CUSTOM_FEAT];
  // Custom side allocation exists only with the custom features option
  assign side_custom_ok = custom_feat;
  // Service preset choice only for hi-rate async service and sync side
  assign svc_choice_ok = ctrl_reg[osa_pkg::CTRL_SVC_HIRATE] &&
                         (side_mode == osa_pkg::OSA_SIDE_MAX || side_mode == osa_pkg::OSA_SIDE_CUSTOM);

  // ==========================================================================
  // APB slave: zero wait states, error on unmapped address or illegal mode
  logic apb_wr;
  logic apb_acc;
  logic addr_ok;
  logic [31:0] wr_ctrl;
  logic        wr_ctrl_bad;

  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pwrite;
  assign pready  = 1'b1;
  assign addr_ok = (paddr == osa_pkg::ADDR_CTRL) || (paddr == osa_pkg::ADDR_CUSTOM) ||
                   (paddr == osa_pkg::ADDR_ALLOC) || (paddr == osa_pkg::ADDR_STATUS) ||
                   (paddr == osa_pkg::ADDR_RATEDIV);
  assign wr_ctrl = pwdata;

  // A mode that the written options cannot serve is refused, keeping the old value
  always_comb begin
    wr_ctrl_bad = 1'b0;
    if (wr_ctrl[osa_pkg::CTRL_SIDE_LSB +: 2] == 2'(osa_pkg::OSA_SIDE_CUSTOM) &&
        !wr_ctrl[osa_pkg::CTRL_CUSTOM_FEAT]) begin
      wr_ctrl_bad = 1'b1;
    end
    if (wr_ctrl[osa_pkg::CTRL_SVC_LSB +: 2] == 2'(osa_pkg::OSA_SVC_CUSTOM) &&
        !wr_ctrl[osa_pkg::CTRL_CUSTOM_FEAT]) begin
      wr_ctrl_bad = 1'b1;
    end
    if (wr_ctrl[osa_pkg::CTRL_SVC_LSB +: 2] != 2'(osa_pkg::OSA_SVC_OFF) &&
        !wr_ctrl[osa_pkg::CTRL_SVC_HIRATE]) begin
      wr_ctrl_bad = 1'b1;
    end
  end

  // Error response for unmapped address, read-only write or refused mode
  always_comb begin
    sel_err = 1'b0;
    if (apb_acc) begin
      if (!addr_ok) begin
        sel_err = 1'b1;
      end else if (pwrite && (paddr == osa_pkg::ADDR_ALLOC || paddr == osa_pkg::ADDR_STATUS)) begin
        sel_err = 1'b1;
      end else if (pwrite && paddr == osa_pkg::ADDR_CTRL && wr_ctrl_bad) begin
        sel_err = 1'b1;
      end
    end
  end
  assign pslverr = sel_err;

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= osa_pkg::CTRL_RESET;
    end else if (apb_wr && paddr == osa_pkg::ADDR_CTRL && !wr_ctrl_bad) begin
      ctrl_reg <= {20'h00000, pwdata[11:0]};
    end
  end

  // Custom code register, three bits per slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      custom_reg <= 24'h000000;
    end else if (apb_wr && paddr == osa_pkg::ADDR_CUSTOM) begin
      custom_reg <= pwdata[23:0];
    end
  end

  // Slot clock divisor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratediv_reg <= '0;
    end else if (apb_wr && paddr == osa_pkg::ADDR_RATEDIV) begin
      ratediv_reg <= pwdata[DIV_W-1:0];
    end
  end

  // Read data from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        osa_pkg::ADDR_CTRL:    prdata <= ctrl_reg;
        osa_pkg::ADDR_CUSTOM:  prdata <= {8'h00, custom_reg};
        osa_pkg::ADDR_ALLOC:   prdata <= {8'h00, cfg.alloc_codes};
        osa_pkg::ADDR_STATUS:  prdata <= {10'h000, svc_choice_ok, side_custom_ok,
                                          cfg.reject_mask, cfg.side_parts, cfg.svc_parts};
        osa_pkg::ADDR_RATEDIV: prdata <= 32'(ratediv_reg);
        default:               prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Allocation per slot
  logic [23:0] alloc;
  logic [7:0]  rej;
  logic [7:0]  svc_ok;
  logic [7:0]  side_ok;
  logic [7:0]  fixed_use_v;
  logic [23:0] fixed_code;
  logic [5:0]  worth [osa_pkg::NUM_SLOTS];
  logic [5:0]  svc_sum;
  logic [5:0]  side_sum;

  assign cfg.custom_codes = custom_reg;

  // Slot permissions and fixed uses
  always_comb begin
    logic cas;
    logic transp;
    logic custom_frm;
    cas        = ctrl_reg[osa_pkg::CTRL_CAS];
    transp     = ctrl_reg[osa_pkg::CTRL_E1_TRANSP];
    custom_frm = ctrl_reg[osa_pkg::CTRL_CUSTOM_FRM];
    svc_ok      = 8'h00;
    side_ok     = 8'h00;
    fixed_use_v = 8'h00;
    fixed_code  = 24'h000000;
    // Free bytes usable by both unless signalling takes them
    for (int i = 0; i < 4; i++) begin
      if (i == osa_pkg::SLOT_FIRST_FREE || i == osa_pkg::SLOT_SECOND_FREE) begin
        worth[i] = osa_pkg::WORTH_BYTE;
        if (cas) begin
          fixed_use_v[i] = 1'b1;
          fixed_code[i*3 +: 3] = osa_pkg::OSA_USE_CAS;
        end else begin
          svc_ok[i]  = 1'b1;
          side_ok[i] = 1'b1;
        end
      end else begin
        worth[i]   = osa_pkg::WORTH_PAIR;
        svc_ok[i]  = 1'b1;
        side_ok[i] = 1'b1;
      end
    end
    worth[osa_pkg::SLOT_ALIGN_B1] = osa_pkg::WORTH_BIT;
    worth[osa_pkg::SLOT_CTRL_B1]  = osa_pkg::WORTH_BIT;
    worth[osa_pkg::SLOT_CTRL_B3]  = osa_pkg::WORTH_BIT;
    worth[osa_pkg::SLOT_CTRL_B4]  = osa_pkg::WORTH_BIT;
    // Transparent spare bits take the alignment bit and the control pairs
    if (transp) begin
      fixed_use_v[osa_pkg::SLOT_ALIGN_B1] = 1'b1;
      fixed_code[osa_pkg::SLOT_ALIGN_B1*3 +: 3] = osa_pkg::OSA_USE_SPAREBITS;
      fixed_use_v[osa_pkg::SLOT_CTRL_B1] = 1'b1;
      fixed_code[osa_pkg::SLOT_CTRL_B1*3 +: 3] = osa_pkg::OSA_USE_SPAREBITS;
      for (int j = 1; j < 3; j++) begin
        svc_ok[j]      = 1'b0;
        side_ok[j]     = 1'b0;
        fixed_use_v[j] = 1'b1;
        fixed_code[j*3 +: 3] = osa_pkg::OSA_USE_SPAREBITS;
      end
    end else begin
      svc_ok[osa_pkg::SLOT_ALIGN_B1] = 1'b1;
      if (side_mode == osa_pkg::OSA_SIDE_LOWRATE) begin
        fixed_use_v[osa_pkg::SLOT_CTRL_B1] = 1'b1;
        fixed_code[osa_pkg::SLOT_CTRL_B1*3 +: 3] = osa_pkg::OSA_USE_LOWRATE;
      end else begin
        svc_ok[osa_pkg::SLOT_CTRL_B1]  = 1'b1;
        side_ok[osa_pkg::SLOT_CTRL_B1] = 1'b1;
      end
    end
    // Backward alarm and multiframe bits free only in custom framing
    if (custom_frm && !ctrl_reg[osa_pkg::CTRL_BA_EN]) begin
      svc_ok[osa_pkg::SLOT_CTRL_B3] = 1'b1;
    end else begin
      fixed_use_v[osa_pkg::SLOT_CTRL_B3] = 1'b1;
      fixed_code[osa_pkg::SLOT_CTRL_B3*3 +: 3] = osa_pkg::OSA_USE_BA;
    end
    if (custom_frm && !ctrl_reg[osa_pkg::CTRL_MFRAME_EN]) begin
      svc_ok[osa_pkg::SLOT_CTRL_B4] = 1'b1;
    end else begin
      fixed_use_v[osa_pkg::SLOT_CTRL_B4] = 1'b1;
      fixed_code[osa_pkg::SLOT_CTRL_B4*3 +: 3] = osa_pkg::OSA_USE_MFRAME;
    end
  end

  // Preset allocation; each slot gets exactly one code
  always_comb begin
    logic [2:0] req;
    logic       side_max;
    logic       pre_side;
    req      = osa_pkg::OSA_USE_UNUSED;
    side_max = 1'b0;
    pre_side = 1'b0;
    alloc = 24'h000000;
    rej   = 8'h00;
    for (int s = 0; s < osa_pkg::NUM_SLOTS; s++) begin
      side_max = (side_mode == osa_pkg::OSA_SIDE_MAX) && side_ok[s] &&
                 (s != osa_pkg::SLOT_ALIGN_B1);
      pre_side = side_max;
      req = osa_pkg::OSA_USE_UNUSED;
      if (side_mode == osa_pkg::OSA_SIDE_CUSTOM || svc_mode == osa_pkg::OSA_SVC_CUSTOM) begin
        req = custom_reg[s*3 +: 3];
        if (side_mode != osa_pkg::OSA_SIDE_CUSTOM && req == osa_pkg::OSA_USE_SIDE) begin
          req = osa_pkg::OSA_USE_UNUSED;
        end
        if (side_mode == osa_pkg::OSA_SIDE_MAX && req == osa_pkg::OSA_USE_SVC && side_max) begin
          rej[s] = 1'b1;
          req = osa_pkg::OSA_USE_SIDE;
        end
      end
      // Presets fill only parts left open, so a custom side map and a
      // service preset share one frame; gated by permission to avoid false rejects
      if (req == osa_pkg::OSA_USE_UNUSED) begin
        if (pre_side) begin
          req = osa_pkg::OSA_USE_SIDE;
        end else if (svc_choice_ok && svc_mode == osa_pkg::OSA_SVC_LEGACY &&
                     s <= osa_pkg::SLOT_SECOND_FREE && svc_ok[s]) begin
          // Legacy preset: both free bytes and control bits 5 to 8
          req = osa_pkg::OSA_USE_SVC;
        end else if (svc_choice_ok && svc_mode == osa_pkg::OSA_SVC_ALL && svc_ok[s]) begin
          req = osa_pkg::OSA_USE_SVC;
        end
      end
      if (fixed_use_v[s]) begin
        if (req != osa_pkg::OSA_USE_UNUSED && req != fixed_code[s*3 +: 3] &&
            (side_mode == osa_pkg::OSA_SIDE_CUSTOM || svc_mode == osa_pkg::OSA_SVC_CUSTOM)) begin
          rej[s] = 1'b1;
        end
        alloc[s*3 +: 3] = fixed_code[s*3 +: 3];
      end else if (req == osa_pkg::OSA_USE_SVC && !svc_ok[s]) begin
        rej[s] = 1'b1;
      end else if (req == osa_pkg::OSA_USE_SIDE && !side_ok[s]) begin
        rej[s] = 1'b1;
      end else if (req == osa_pkg::OSA_USE_SVC || req == osa_pkg::OSA_USE_SIDE) begin
        alloc[s*3 +: 3] = req;
      end else if (req != osa_pkg::OSA_USE_UNUSED) begin
        rej[s] = 1'b1;
      end
    end
  end

  // Share totals in 32nds; low-rate side only ever counts control bit 1
  always_comb begin
    svc_sum  = 6'h00;
    side_sum = 6'h00;
    for (int k = 0; k < osa_pkg::NUM_SLOTS; k++) begin
      if (alloc[k*3 +: 3] == osa_pkg::OSA_USE_SVC) svc_sum = svc_sum + worth[k];
      if (alloc[k*3 +: 3] == osa_pkg::OSA_USE_SIDE) side_sum = side_sum + worth[k];
    end
    if (side_mode == osa_pkg::OSA_SIDE_LOWRATE && !ctrl_reg[osa_pkg::CTRL_E1_TRANSP]) begin
      side_sum = osa_pkg::WORTH_BIT;
    end
  end

  assign cfg.alloc_codes = alloc;
  assign cfg.reject_mask = rej;
  assign cfg.svc_parts   = svc_sum;
  assign cfg.side_parts  = side_sum;

  // ==========================================================================
  // Bit steering on the overhead stream
  logic       slot_tick;
  logic [4:0] part_idx;
  logic [3:0] cur_slot;
  logic [2:0] cur_code;

  osa_rate_gen #(.DIV_W(DIV_W)) i_osa_rate_gen (
    .pclk      (pclk),
    .presetn   (presetn),
    .div       (ratediv_reg),
    .slot_tick (slot_tick),
    .part_idx  (part_idx)
  );

  osa_slot_map i_osa_slot_map (
    .part_idx (part_idx),
    .slot     (cur_slot)
  );

  // Low-rate mode uses control bit 1 directly as the side channel
  always_comb begin
    if (cur_slot < 4'h8) begin
      cur_code = alloc[cur_slot[2:0]*3 +: 3];
    end else begin
      cur_code = osa_pkg::OSA_USE_UNUSED;
    end
    if (cur_code == osa_pkg::OSA_USE_LOWRATE) begin
      cur_code = osa_pkg::OSA_USE_SIDE;
    end
  end

  // Transmit mux and receive demux, one register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oh_tx_bit     <= 1'b1;
      oh_tx_valid   <= 1'b0;
      oh_part_idx   <= 5'h00;
      svc_rx_bit    <= 1'b1;
      svc_rx_valid  <= 1'b0;
      side_rx_bit   <= 1'b1;
      side_rx_valid <= 1'b0;
    end else begin
      oh_tx_valid   <= slot_tick;
      oh_part_idx   <= part_idx;
      svc_rx_valid  <= slot_tick && (cur_code == osa_pkg::OSA_USE_SVC);
      side_rx_valid <= slot_tick && (cur_code == osa_pkg::OSA_USE_SIDE);
      if (slot_tick) begin
        unique case (cur_code)
          osa_pkg::OSA_USE_SVC:  oh_tx_bit <= svc_tx_bit;
          osa_pkg::OSA_USE_SIDE: oh_tx_bit <= side_tx_bit;
          default:               oh_tx_bit <= 1'b1; // Idle ones on unused parts
        endcase
        svc_rx_bit  <= oh_rx_bit;
        side_rx_bit <= oh_rx_bit;
      end
    end
  end

  // ==========================================================================
  // Rate figures: main-rate divisors for service baud and side async rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_baud_div   <= 16'h0000;
      side_async_div <= 16'h0000;
    end else begin
      // Legacy preset: baud ceiling about main rate / 23
      if (svc_mode == osa_pkg::OSA_SVC_LEGACY) begin
        svc_baud_div <= 16'(osa_pkg::LEGACY_BAUD_DIV);
      end else if (svc_sum != 6'h00) begin
        // Scales with share: 460 divided by the service parts in 32nds
        svc_baud_div <= 16'(16'd460 / {10'h000, svc_sum});
      end else begin
        svc_baud_div <= 16'h0000;
      end
      if (side_mode == osa_pkg::OSA_SIDE_LOWRATE) begin
        side_async_div <= 16'(osa_pkg::LOWRATE_DIV);
      end else if (side_mode == osa_pkg::OSA_SIDE_MAX) begin
        side_async_div <= 16'(100 / osa_pkg::MAX_ASYNC_PCT);
      end else if (side_sum != 6'h00) begin
        side_async_div <= 16'(16'd2100 / {10'h000, side_sum});
      end else begin
        side_async_div <= 16'h0000;
      end
    end
  end
endmodule

// [verif/osa_top_sva.sv]
`timescale 1ns/10ps
// ====================
// Port checks
module osa_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  input wire logic        oh_tx_valid,
  input wire logic [4:0]  oh_part_idx,
  input wire logic        svc_rx_valid,
  input wire logic        side_rx_valid,
  input wire logic [15:0] side_async_div
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Slots the side channel may never own; low-rate side only on control bit 1
  a_align_side: assert property (side_rx_valid |-> oh_part_idx != 5'h14)
    else $error("align bit to side");
  a_alarm_side: assert property (side_rx_valid |-> oh_part_idx != 5'h16)
    else $error("bit 3 to side");
  a_mframe_side: assert property (side_rx_valid |-> oh_part_idx != 5'h17)
    else $error("bit 4 to side");
  a_low_rate: assert property (side_rx_valid && side_async_div == 16'h07D0 |-> oh_part_idx == 5'h15)
    else $error("low rate off bit 1");
  // One owner per part; fixed parts never delivered
  a_one_user: assert property (svc_rx_valid |-> !side_rx_valid)
    else $error("two users");
  a_fixed_parts: assert property (svc_rx_valid || side_rx_valid |-> oh_tx_valid && oh_part_idx < 5'h18)
    else $error("fixed part delivered");
  // Bus error only in access; parts advance one per tick
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("stray bus error");
  a_part_step: assert property (oh_tx_valid && $past(oh_tx_valid) |-> oh_part_idx == $past(oh_part_idx) + 5'h01)
    else $error("part skipped");
  // Main scenarios reached
  c_low_rate: cover property (side_rx_valid && side_async_div == 16'h07D0);
  c_svc: cover property (svc_rx_valid);
  c_err: cover property (pslverr);
endmodule

bind osa_top osa_top_sva i_osa_top_sva (.pclk, .presetn, .psel, .penable, .pslverr, .oh_tx_valid, .oh_part_idx,
  .svc_rx_valid, .side_rx_valid, .side_async_div);

// [verif/osa_far_modem.sv]
`timescale 1ns/10ps
// ====================
// Far modem: returns a steady overhead level
module osa_far_modem (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic rx_level,
  output logic      oh_rx_bit
);
  // Idle ones in reset; level moves only between phases, so no sample is ambiguous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oh_rx_bit <= 1'b1;
    end else begin
      oh_rx_bit <= rx_level;
    end
  end
endmodule

// [verif/tb_overhead_slot_allocator.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("mismatch %0t %h %h", $time, a, b); end end
// ====================
// Allocator bench
module tb_overhead_slot_allocator;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        svc_tx_bit, side_tx_bit, rx_level, oh_rx_bit, oh_tx_bit, oh_tx_valid;
  logic        svc_rx_bit, svc_rx_valid, side_rx_bit, side_rx_valid;
  logic [4:0]  oh_part_idx;
  logic [11:0] paddr;
  logic [15:0] svc_baud_div, side_async_div;
  logic [31:0] pwdata, prdata;
  logic [64:0] e;
  logic [64:0] exp_q[$];
  logic [1:0]  own[32];
  integer      seed = 32'h39E38C8A;
  int          fails = 0;
  int          n_tests = 0;

  osa_top #(.DIV_W(16)) i_osa_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .svc_tx_bit, .side_tx_bit, .oh_tx_bit, .oh_tx_valid, .oh_part_idx, .oh_rx_bit, .svc_rx_bit,
    .svc_rx_valid, .side_rx_bit, .side_rx_valid, .svc_baud_div, .side_async_div);
  osa_far_modem i_osa_far_modem (.pclk, .presetn, .rx_level, .oh_rx_bit);

  // Clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Watcher: bus answers in request order; stream bits against the owner table (3 = settling)
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      e = exp_q.pop_front();
      `CHK({pslverr, prdata & e[31:0]}, e[64:32])
    end
    if (oh_tx_valid && ^own[oh_part_idx]) `CHK(oh_tx_bit, own[oh_part_idx][0] ? svc_tx_bit : side_tx_bit)
    if (svc_rx_valid && own[oh_part_idx] !== 2'h3) `CHK({own[oh_part_idx], svc_rx_bit}, {2'h1, rx_level})
    if (side_rx_valid && own[oh_part_idx] !== 2'h3) `CHK({own[oh_part_idx], side_rx_bit}, {2'h2, rx_level})
  end

  // One transfer; the answer is noted before the request goes out
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, x, m, input logic err);
    int k;
    exp_q.push_back({err, x, m});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20) begin
      fails++;
      summarize();
    end
  endtask

  // Configure, read status, then arm the owner table for one frame and more
  task automatic phase(input logic [31:0] c, u, input logic [23:0] sv, sd, input logic [31:0] st, m);
    for (int i = 0; i < 32; i++) own[i] <= 2'h3;
    {svc_tx_bit, side_tx_bit, rx_level} <= 3'($random(seed));
    apb(1'b1, osa_pkg::ADDR_CUSTOM, u, 32'h0, 32'h0, 1'b0);
    apb(1'b1, osa_pkg::ADDR_CTRL, c, 32'h0, 32'h0, 1'b0);
    apb(1'b0, osa_pkg::ADDR_STATUS, 32'h0, st, m, 1'b0);
    for (int i = 0; i < 32; i++) own[i] <= i < 24 ? {sd[i], sv[i]} : 2'h0;
    repeat (40) @(posedge pclk);
  endtask

  task automatic summarize;
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence; divider 0 keeps a tick every cycle
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {svc_tx_bit, side_tx_bit, rx_level} = 3'h0;
    for (int i = 0; i < 32; i++) own[i] = 2'h3;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, osa_pkg::ADDR_CTRL, 32'h0, 32'h180, 32'hFFFFFFFF, 1'b0);
    apb(1'b1, osa_pkg::ADDR_RATEDIV, 32'h0, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h014, 32'h0, 32'h0, 32'h0, 1'b1);
    apb(1'b1, osa_pkg::ADDR_STATUS, 32'h0, 32'h0, 32'h0, 1'b1);
    apb(1'b1, osa_pkg::ADDR_CTRL, 32'h18C, 32'h0, 32'h0, 1'b1);
    apb(1'b0, osa_pkg::ADDR_CTRL, 32'h0, 32'h180, 32'hFFFFFFFF, 1'b0);
    phase(32'h188, 32'h0, 24'h0, 24'h2FFFFF, 32'h540, 32'h3FFFFF);
    `CHK(side_async_div, 16'h0064)
    phase(32'h59D, 32'h0, 24'h0FFFFF, 24'h0, 32'h300014, 32'h3FFFFF);
    `CHK(svc_baud_div, 16'h0017)
    phase(32'hD9F, 32'h12, 24'h3CFF00, 24'h0300FF, 32'h30028C, 32'h3FFFFF);
    apb(1'b0, osa_pkg::ADDR_CTRL, 32'h0, 32'hD9F, 32'hFFFFFFFF, 1'b0);
    `CHK({svc_baud_div, side_async_div}, 32'h002600D2)
    phase(32'h45E, 32'h442401, 24'h4000FF, 24'h00FF00, 32'h390209, 32'h3FFFFF);
    apb(1'b0, osa_pkg::ADDR_ALLOC, 32'h0, 32'h40401, 32'hFFFFFF, 1'b0);
    phase(32'h47E, 32'h442401, 24'h400000, 24'h0, 32'h399001, 32'h3FFFFF);
    phase(32'h184, 32'h0, 24'h0, 24'h200000, 32'h40, 32'h3FFFFF);
    `CHK(side_async_div, 16'h07D0)
    phase(32'h79F, 32'h0, 24'h00FFFF, 24'h0, 32'h300010, 32'h3FFFFF);
    apb(1'b1, osa_pkg::ADDR_CTRL, 32'h19D, 32'h0, 32'h0, 1'b1);
    phase(32'h591, 32'h0, 24'h0, 24'h0, 32'h100000, 32'h3FFFFF);
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule
